/* rtl/dsarc_pkg.sv */
package dsarc_pkg;
   // Result word width on the parallel bus
   localparam int DSARC_WORD_W = 12;
   typedef logic [DSARC_WORD_W-1:0] dsarc_word_t;

   // One simultaneous conversion of a pair
   typedef struct packed {
      dsarc_word_t first;
      dsarc_word_t second;
   } dsarc_pair_s;

   // Pin group after synchronisation
   typedef struct packed {
      logic auto_power_down;
      logic read_n;
      logic chip_select_n;
      logic pair_select;
      logic conversion_start_n;
   } dsarc_pins_s;

   localparam dsarc_pins_s DSARC_PINS_RESET = '{
      auto_power_down: 1'b0,
      read_n: 1'b1,
      chip_select_n: 1'b1,
      pair_select: 1'b0,
      conversion_start_n: 1'b1
   };

   typedef enum logic [1:0] {
      DSARC_IDLE,
      DSARC_CONVERT,
      DSARC_LOAD
   } dsarc_state_e;

   // Timing
   localparam int DSARC_CLOCK_PERIOD_NS = 50;
   localparam int DSARC_CONV_TIME_NS = 3600;
   localparam int DSARC_THROUGHPUT_NS = 4000;
   localparam int DSARC_SYNC_CYCLES = 2;
   localparam int DSARC_DETECT_CYCLES = 1;
   localparam int DSARC_LOAD_CYCLES = 2;
   localparam int DSARC_CNT_W = 7;
   localparam int DSARC_FIFO_DEPTH = 2;
   localparam int DSARC_RESULT_RESET = 0;
endpackage

/* rtl/dsarc_read_control.sv */
`timescale 1ns/1ns
`default_nettype none
module dsarc_read_control
   import dsarc_pkg::*;
#(
   parameter int CONV_TIME_NS = DSARC_CONV_TIME_NS,
   parameter int CLOCK_PERIOD_NS = DSARC_CLOCK_PERIOD_NS
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic conversion_start_n,
   input wire logic pair_select,
   input wire logic chip_select_n,
   input wire logic read_n,
   input wire logic auto_power_down,
   input wire dsarc_pair_s conv_result,
   output logic hold_q,
   output logic busy_q,
   output logic mux_select_q,
   output logic power_down_q,
   output dsarc_word_t data_q,
   output logic data_oe_n_q
);
   // Longest time rounds down
   localparam int CONV_CYCLES = CONV_TIME_NS / CLOCK_PERIOD_NS;
   localparam int BUSY_CYCLES = CONV_CYCLES - DSARC_SYNC_CYCLES - DSARC_DETECT_CYCLES;
   localparam int CONVERT_CYCLES = BUSY_CYCLES - DSARC_LOAD_CYCLES;
   localparam logic [DSARC_CNT_W-1:0] CONVERT_LAST =
      DSARC_CNT_W'(CONVERT_CYCLES - 1);
   localparam int THROUGHPUT_CYCLES = DSARC_THROUGHPUT_NS / CLOCK_PERIOD_NS;

   generate
      if (CONVERT_CYCLES < 1 || CONVERT_CYCLES >= (1 << DSARC_CNT_W) ||
          BUSY_CYCLES + DSARC_SYNC_CYCLES >= THROUGHPUT_CYCLES) begin : g_bad_timing
         $error("dsarc_read_control: conversion timing cannot be served");
      end
   endgenerate

   dsarc_pins_s pins_in;
   dsarc_pins_s meta_q;
   dsarc_pins_s sync_q;
   logic start_prev_q;
   logic read_prev_q;
   dsarc_state_e state_q;
   dsarc_state_e state_d;
   logic [DSARC_CNT_W-1:0] cnt_q;
   logic load_idx_q;
   dsarc_word_t mem_q [DSARC_FIFO_DEPTH];
   logic wr_ptr_q;
   logic rd_ptr_q;
   logic [1:0] count_q;

   assign pins_in = '{
      auto_power_down: auto_power_down,
      read_n: read_n,
      chip_select_n: chip_select_n,
      pair_select: pair_select,
      conversion_start_n: conversion_start_n
   };

   // Two-flop synchronisers; only sync_q is looked at
   always_ff @(posedge clock) begin
      if (reset) begin
         meta_q <= DSARC_PINS_RESET;
         sync_q <= DSARC_PINS_RESET;
      end else begin
         meta_q <= pins_in;
         sync_q <= meta_q;
      end
   end

   wire start_fall = start_prev_q && !sync_q.conversion_start_n;
   wire start_take = start_fall && (state_q == DSARC_IDLE);
   wire read_active = !sync_q.chip_select_n && !sync_q.read_n;
   wire read_end = read_prev_q && !read_active;
   wire conv_done = (state_q == DSARC_CONVERT) && (cnt_q == CONVERT_LAST);

   // Buffer write side: the load sequencer waits on wr_ready
   wire wr_ready = (count_q != 2'(DSARC_FIFO_DEPTH));
   wire wr_valid = (state_q == DSARC_LOAD);
   wire wr_fire = wr_valid && wr_ready;
   wire load_last = wr_fire && load_idx_q;
   dsarc_word_t wr_word;
   assign wr_word = load_idx_q ? conv_result.second : conv_result.first;
   // Buffer read side: drained by the end of each read strobe
   wire rd_valid = (count_q != 2'd0);
   wire rd_fire = rd_valid && read_end;
   dsarc_word_t rd_word;
   assign rd_word = mem_q[rd_ptr_q];

   always_comb begin
      state_d = state_q;
      case (state_q)
         DSARC_IDLE: begin
            if (start_take) begin
               state_d = DSARC_CONVERT;
            end
         end
         DSARC_CONVERT: begin
            if (conv_done) begin
               state_d = DSARC_LOAD;
            end
         end
         DSARC_LOAD: begin
            if (load_last) begin
               state_d = DSARC_IDLE;
            end
         end
         default: state_d = DSARC_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         state_q <= DSARC_IDLE;
         start_prev_q <= 1'b1;
         read_prev_q <= 1'b0;
         cnt_q <= '0;
         load_idx_q <= 1'b0;
      end else begin
         state_q <= state_d;
         start_prev_q <= sync_q.conversion_start_n;
         read_prev_q <= read_active;
         cnt_q <= (state_q == DSARC_CONVERT) ? cnt_q + 1'b1 : '0;
         if (wr_fire) begin
            load_idx_q <= !load_idx_q;
         end
      end
   end

   // Track/hold, busy and pair latched at the moment of start
   always_ff @(posedge clock) begin
      if (reset) begin
         hold_q <= 1'b0;
         busy_q <= 1'b0;
         mux_select_q <= 1'b0;
      end else if (start_take) begin
         hold_q <= 1'b1;
         busy_q <= 1'b1;
         mux_select_q <= sync_q.pair_select;
      end else if (load_last) begin
         hold_q <= 1'b0;
         busy_q <= 1'b0;
      end
   end

   // Sleep once results are stored; the start edge wakes the part on the same clock edge that starts conversion
   always_ff @(posedge clock) begin
      if (reset) begin
         power_down_q <= 1'b0;
      end else if (start_take) begin
         power_down_q <= 1'b0;
      end else if (load_last) begin
         power_down_q <= sync_q.auto_power_down;
      end else if (!sync_q.auto_power_down) begin
         power_down_q <= 1'b0;
      end
   end

   // Two-entry buffer; a new start flushes unread words
   always_ff @(posedge clock) begin
      if (reset) begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         count_q <= 2'd0;
      end else if (start_take) begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         count_q <= 2'd0;
      end else begin
         if (wr_fire) begin
            wr_ptr_q <= !wr_ptr_q;
         end
         if (rd_fire) begin
            rd_ptr_q <= !rd_ptr_q;
         end
         count_q <= count_q + 2'(wr_fire) - 2'(rd_fire);
      end
   end

   always_ff @(posedge clock) begin
      if (wr_fire) begin
         mem_q[wr_ptr_q] <= wr_word;
      end
   end

   // Bus driven only while chip select and read strobe are both low
   always_ff @(posedge clock) begin
      if (reset) begin
         data_q <= DSARC_WORD_W'(DSARC_RESULT_RESET);
         data_oe_n_q <= 1'b1;
      end else begin
         data_oe_n_q <= !read_active;
         if (read_active && !read_prev_q) begin
            data_q <= rd_valid ? rd_word : DSARC_WORD_W'(DSARC_RESULT_RESET);
         end
      end
   end

   // Helper: busy length
   logic [DSARC_CNT_W-1:0] busy_len_q;
   always_ff @(posedge clock) begin
      if (reset) begin
         busy_len_q <= '0;
      end else begin
         busy_len_q <= busy_q ? busy_len_q + 1'b1 : '0;
      end
   end

   sequence s_take;
      start_take;
   endsequence

   sequence s_load_pair;
      wr_fire && !load_idx_q ##1 wr_fire && load_idx_q;
   endsequence

   a_start_hold: assert property (@(posedge clock) disable iff (reset)
      s_take |=> hold_q && busy_q && state_q == DSARC_CONVERT && cnt_q == '0)
      else $error("start did not place both track/holds in hold");

   a_done_ready: assert property (@(posedge clock) disable iff (reset)
      $fell(busy_q) |-> count_q == 2'd2 && !hold_q)
      else $error("busy fell without both results stored");

   a_first_word: assert property (@(posedge clock) disable iff (reset)
      s_load_pair |=> mem_q[rd_ptr_q] == $past(conv_result.first, 2))
      else $error("first stored word is not first input of the pair");

   a_second_word: assert property (@(posedge clock) disable iff (reset)
      s_load_pair |=> mem_q[!rd_ptr_q] == $past(conv_result.second, 1))
      else $error("second stored word is not second input of the pair");

   a_pair_route: assert property (@(posedge clock) disable iff (reset)
      s_take |=> mux_select_q == $past(sync_q.pair_select) ##1 $stable(mux_select_q))
      else $error("pair select not applied or not held");

   a_bus_drive: assert property (@(posedge clock) disable iff (reset)
      (read_active |=> !data_oe_n_q) and (!read_active |=> data_oe_n_q))
      else $error("data bus enable does not follow chip select and read");

   a_conv_time: assert property (@(posedge clock) disable iff (reset)
      $fell(busy_q) |-> $past(busy_len_q) == DSARC_CNT_W'(BUSY_CYCLES - 1))
      else $error("conversion time differs from its figure");

   a_power_down: assert property (@(posedge clock) disable iff (reset)
      (busy_q |-> !power_down_q) and
      (load_last && sync_q.auto_power_down |=> power_down_q))
      else $error("auto power-down wrong around a conversion");

   a_rate: assert property (@(posedge clock) disable iff (reset)
      $rose(busy_q) |-> ##[1:77] !busy_q)
      else $error("conversion too slow for the sample rate");

   a_read_restart: assert property (@(posedge clock) disable iff (reset)
      s_take |=> count_q == 2'd0 && rd_ptr_q == 1'b0)
      else $error("read order not restarted by new conversion");
endmodule
`default_nettype wire

/* test/dsarc_conv_model.sv */
`timescale 1ns/1ns
`default_nettype none
module dsarc_conv_model
   import dsarc_pkg::*;
(
   input wire logic clock,
   input wire logic hold_q,
   input wire logic mux_select_q,
   input wire dsarc_pair_s pair_a,
   input wire dsarc_pair_s pair_b,
   output dsarc_pair_s conv_result
);
   dsarc_pair_s junk_q = '0;
   // Outside hold the result lines carry nothing usable
   always_ff @(posedge clock) junk_q <= ~junk_q;
   assign conv_result = hold_q ? (mux_select_q ? pair_b : pair_a) : junk_q;
endmodule
`default_nettype wire

/* test/tb_dsarc_read_control.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin n_fail++; \
   $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module tb_dsarc_read_control;
   import dsarc_pkg::*;
   typedef struct {logic ps; logic apd; dsarc_pair_s a; dsarc_pair_s b;} dsarc_row_s;
   logic clock = 0, reset = 1, conversion_start_n = 1, pair_select = 0;
   logic chip_select_n = 1, read_n = 1, auto_power_down = 0;
   dsarc_pair_s pair_a = '0, pair_b = '0, conv_result;
   logic hold_q, busy_q, mux_select_q, power_down_q, data_oe_n_q;
   dsarc_word_t data_q;
   int n_fail = 0, checked = 0;
   dsarc_row_s rows [4] = '{
      '{1'b0, 1'b0, {12'h1a1, 12'h1a2}, {12'h1b1, 12'h1b2}},
      '{1'b1, 1'b0, {12'h2a1, 12'h2a2}, {12'h2b1, 12'h2b2}},
      '{1'b0, 1'b1, {12'hfff, 12'h000}, {12'h555, 12'haaa}},
      '{1'b1, 1'b1, {12'h800, 12'h001}, {12'h7ff, 12'hffe}}};

   dsarc_read_control uut (.clock(clock), .reset(reset),
      .conversion_start_n(conversion_start_n), .pair_select(pair_select),
      .chip_select_n(chip_select_n), .read_n(read_n), .auto_power_down(auto_power_down),
      .conv_result(conv_result), .hold_q(hold_q), .busy_q(busy_q),
      .mux_select_q(mux_select_q), .power_down_q(power_down_q), .data_q(data_q),
      .data_oe_n_q(data_oe_n_q));
   dsarc_conv_model conv (.clock(clock), .hold_q(hold_q), .mux_select_q(mux_select_q),
      .pair_a(pair_a), .pair_b(pair_b), .conv_result(conv_result));

   initial begin
      forever #25 clock = ~clock;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   // A second start edge in mid-conversion when poke is set
   task automatic convert(input logic ps, input logic poke);
      int n;
      n = 0;
      conversion_start_n = 1;
      cyc(4);
      conversion_start_n = 0;
      pair_select = ps;
      while (busy_q !== 1'b1 && n < 200) begin cyc(1); n++; end
      `CHK("busy rise", 3, n)
      `CHK("hold", 1'b1, hold_q)
      `CHK("sleep off", 1'b0, power_down_q)
      pair_select = ~ps;
      while (busy_q !== 1'b0 && n < 200) begin
         cyc(1);
         n++;
         conversion_start_n = !(poke && n >= 10 && n < 14);
      end
      `CHK("busy fall", 72, n)
      `CHK("hold off", 1'b0, hold_q)
      `CHK("mux", ps, mux_select_q)
      cyc(3);
      `CHK("sleep", auto_power_down, power_down_q)
   endtask

   task automatic rd(input dsarc_word_t exp);
      int n;
      n = 0;
      chip_select_n = 0;
      read_n = 0;
      while (data_oe_n_q !== 1'b0 && n < 20) begin cyc(1); n++; end
      `CHK("oe on", 3, n)
      `CHK("data", exp, data_q)
      cyc(2);
      read_n = 1;
      chip_select_n = 1;
      n = 0;
      while (data_oe_n_q !== 1'b1 && n < 20) begin cyc(1); n++; end
      `CHK("oe off", 3, n)
      cyc(2);
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      repeat (4000) @(posedge clock);
      n_fail++;
      wrap_up();
   end

   initial begin
      cyc(10);
      `CHK("reset busy", 1'b0, busy_q)
      `CHK("reset oe", 1'b1, data_oe_n_q)
      reset = 0;
      foreach (rows[i]) begin
         pair_a = rows[i].a;
         pair_b = rows[i].b;
         auto_power_down = rows[i].apd;
         convert(rows[i].ps, 1'b0);
         rd(rows[i].ps ? rows[i].b.first : rows[i].a.first);
         rd(rows[i].ps ? rows[i].b.second : rows[i].a.second);
         rd(12'h000);
      end
      // Start edge while busy must not restart anything
      auto_power_down = 0;
      pair_b = {12'h2b1, 12'h2b2};
      convert(1'b1, 1'b1);
      rd(12'h2b1);
      rd(12'h2b2);
      // Half-read pair, then a new conversion restarts the order
      pair_a = {12'h3a1, 12'h3a2};
      convert(1'b0, 1'b0);
      rd(12'h3a1);
      pair_a = {12'h4a1, 12'h4a2};
      convert(1'b0, 1'b0);
      rd(12'h4a1);
      rd(12'h4a2);
      // Reset in mid-conversion empties everything
      pair_a = {12'h5a1, 12'h5a2};
      conversion_start_n = 1;
      cyc(4);
      conversion_start_n = 0;
      cyc(20);
      // Start pin idles high so the release shows no false start edge
      conversion_start_n = 1;
      reset = 1;
      cyc(2);
      `CHK("mid reset busy", 1'b0, busy_q)
      `CHK("mid reset hold", 1'b0, hold_q)
      reset = 0;
      cyc(3);
      `CHK("no start after reset", 1'b0, busy_q)
      rd(12'h000);
      wrap_up();
   end
endmodule
`default_nettype wire
